// file: core/mps_pin_logic.sv
// nibble / seven-wire PHY pin logic: transmit, receive, packet compress
//
// Behaviour
// RQ1: tx enable high exactly while nibbles carry preamble through CRC.
// RQ2: in serial mode the serial transmit enable rises when sending.
// RQ3: tx error only changes on the transmit clock edge.
// RQ4: the PHY emits invalid symbols when tx error is seen; the bench PHY model has no tx error or transmit data input.
// RQ5: serial mode: compress output activates right after destination address.
// RQ6: compress polarity and match/mismatch sense are software chosen.
// RQ7: PHY raises carrier sense asynchronously on non-idle medium.
// RQ8: serial PHY asserts carrier sense for receive data and own sends.
// RQ9: PHY supplies free-running receive clock, 25 or 2.5 MHz; the bench PHY model runs it at a 15 ns period.
// RQ10: PHY updates rx lines on falling edge; device captures on rising.
// RQ11: received first nibble forms byte low half, bit zero first.
// RQ12: serial mode receives on lowest data line only.
// RQ13: transmit data and enable launch from transmit clock rising edge.
// RQ14: bytes go out low nibble first, bit zero is byte LSB.
// RQ15: PHY holds rx valid exactly while rx data is valid.
// RQ16: carrier sense passes two flip-flops before use.
// RQ17: one setting selects nibble or seven-wire use of the pins.
`timescale 1ns/1ps
`default_nettype none
`include "mps_consts.svh"
module mps_pin_logic
	import mps_pkg::*;
(
	input  wire logic                 sys_clk_i,
	input  wire logic                 reset_i,
	input  wire logic                 tx_clk_i,
	input  wire logic                 rx_clk_i,
	input  wire mps_mode_type         mode_i,
	input  wire mps_compress_cfg_type compress_cfg_i,
	input  wire logic                 tx_start_i,
	input  wire logic [7:0]           tx_byte_i,
	input  wire logic                 tx_last_i,
	input  wire logic                 tx_error_req_i,
	input  wire logic                 da_match_i,
	input  wire logic [3:0]           rxd_i,
	input  wire logic                 rx_dv_i,
	input  wire logic                 rx_err_i,
	input  wire logic                 carrier_sense_i,
	output logic                      tx_take_o,
	output logic [3:0]                txd_o,
	output logic                      tx_en_o,
	output logic                      tx_err_o,
	output logic                      serial_transmit_enable_o,
	output logic                      packet_compress_output_o,
	output mps_byte_type              rx_byte_o,
	output logic                      rx_byte_valid_o,
	output logic [`MPS_DA_BITS-1:0]   rx_da_o,
	output logic                      carrier_o
);
	// ----------------------------------------------------------------
	// transmit domain (tx_clk_i)
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {TX_IDLE, TX_LOW, TX_HIGH} mps_tx_state_type;
	mps_tx_state_type tx_state;
	mps_tx_state_type next_tx_state;
	logic             tx_reset;
	logic             tx_mode_serial;
	logic             tx_err_sync;
	logic [7:0]       tx_hold;
	logic             tx_hold_last;
	logic [2:0]       tx_bit;
	logic             tx_busy;

	// reset and config cross as levels; tx inputs assumed on tx clock
	mps_sync #(.WIDTH(2)) u_tx_sync
	(
		.clk_i   (tx_clk_i),
		.reset_i (1'b0),
		.async_i ({reset_i, mode_i == MPS_MODE_SERIAL}),
		.sync_o  ({tx_reset, tx_mode_serial})
	);

	assign tx_busy = (tx_state != TX_IDLE);

	always_comb
	begin
		next_tx_state = tx_state;
		unique case (tx_state)
			TX_IDLE:
				if (tx_start_i)
					next_tx_state = TX_LOW;
			TX_LOW:
				if (!tx_mode_serial)
					next_tx_state = TX_HIGH;
				else if (tx_bit == 3'd7)
					next_tx_state = tx_hold_last ? TX_IDLE : TX_LOW;
			TX_HIGH:
				next_tx_state = tx_hold_last ? TX_IDLE : TX_LOW;
		endcase
	end

	always_ff @(posedge tx_clk_i) // RQ13
	begin
		if (tx_reset)
		begin
			tx_state                 <= TX_IDLE;
			tx_hold                  <= 8'h00;
			tx_hold_last             <= 1'b0;
			tx_bit                   <= 3'd0;
			txd_o                    <= 4'h0;
			tx_en_o                  <= 1'b0;
			tx_err_o                 <= 1'b0;
			tx_take_o                <= 1'b0;
			serial_transmit_enable_o <= 1'b0;
		end
		else
		begin
			tx_state  <= next_tx_state;
			tx_take_o <= 1'b0;
			tx_err_o  <= tx_busy && tx_error_req_i; // RQ3
			if (next_tx_state != TX_IDLE &&
			    (tx_state == TX_IDLE || next_tx_state == TX_LOW &&
			     (tx_state == TX_HIGH || tx_bit == 3'd7)))
			begin
				tx_hold      <= tx_byte_i;
				tx_hold_last <= tx_last_i;
				tx_take_o    <= 1'b1;
				tx_bit       <= 3'd0;
			end
			else if (tx_state == TX_LOW && tx_mode_serial)
				tx_bit <= tx_bit + 3'd1;
			// low nibble first, bit zero is the byte LSB
			if (next_tx_state == TX_LOW && !tx_mode_serial)
				txd_o <= (tx_state == TX_IDLE || tx_state == TX_HIGH ||
				          tx_bit == 3'd7) ? tx_byte_i[3:0] : tx_hold[3:0]; // RQ14
			else if (next_tx_state == TX_HIGH)
				txd_o <= tx_hold[7:4]; // RQ14
			else if (next_tx_state == TX_LOW)
				txd_o <= {3'b000, (tx_state != TX_LOW || tx_bit == 3'd7) ?
				          tx_byte_i[0] : tx_hold[tx_bit + 3'd1]};
			else
				txd_o <= 4'h0;
			tx_en_o <= (next_tx_state != TX_IDLE) && !tx_mode_serial; // RQ1
			serial_transmit_enable_o <=
				(next_tx_state != TX_IDLE) && tx_mode_serial; // RQ2
		end
	end

	// ----------------------------------------------------------------
	// receive domain (rx_clk_i)
	// ----------------------------------------------------------------
	logic       rx_reset;
	logic       rx_mode_serial;
	logic [7:0] rx_shift;
	logic [2:0] rx_cnt;
	logic       rx_carrier;
	logic       rx_got_sfd;
	logic [3:0] rx_da_count;
	logic       rx_err_seen;
	logic       rx_toggle;
	logic       compress_hit;
	logic [7:0] next_rx_shift;
	logic       rx_byte_done;
	logic       rx_dv_eff;

	mps_sync #(.WIDTH(3)) u_rx_sync
	(
		.clk_i   (rx_clk_i),
		.reset_i (1'b0),
		.async_i ({reset_i, mode_i == MPS_MODE_SERIAL,
		           carrier_sense_i}),                 // RQ16 RQ17
		.sync_o  ({rx_reset, rx_mode_serial, rx_carrier})
	);

	// serial mode frames the receive with carrier sense, data on line 0
	// synced carrier loses one or two preamble bits, by clock phase; the delimiter hunt absorbs it
	assign rx_dv_eff     = rx_mode_serial ? rx_carrier : rx_dv_i; // RQ16
	assign next_rx_shift = rx_mode_serial ?
		{rxd_i[0], rx_shift[7:1]} :                          // RQ12
		{rxd_i, rx_shift[7:4]};                              // RQ11
	assign rx_byte_done  = rx_mode_serial ? (rx_cnt == 3'd7) :
	                                        (rx_cnt == 3'd1);
	// match sense and polarity from software
	assign compress_hit  = (da_match_i ^ compress_cfg_i.on_mismatch); // RQ6

	// sampled on rising edge; PHY drives on the falling one
	always_ff @(posedge rx_clk_i) // RQ10
	begin
		if (rx_reset || !rx_dv_eff)
		begin
			rx_shift    <= 8'h00;
			rx_cnt      <= 3'd0;
			rx_got_sfd  <= 1'b0;
			rx_da_count <= 4'd0;
			rx_err_seen <= 1'b0;
			packet_compress_output_o <= ~compress_cfg_i.polarity_high;
			// address and last byte survive the frame end, not a reset
			if (rx_reset)
			begin
				rx_toggle <= 1'b0;
				rx_da_o   <= '0;
				rx_byte_o <= '0;
			end
		end
		else
		begin
			rx_shift    <= next_rx_shift;
			rx_err_seen <= rx_err_seen | (rx_err_i & !rx_mode_serial);
			if (!rx_got_sfd)
			begin
				// hunt for the start delimiter on any bit (serial) or nibble alignment
				if (next_rx_shift == `MPS_SFD_BYTE)
				begin
					rx_got_sfd <= 1'b1;
					rx_cnt     <= 3'd0;
				end
			end
			else
			begin
				rx_cnt <= rx_byte_done ? 3'd0 : rx_cnt + 3'd1;
				if (rx_byte_done)
				begin
					rx_byte_o.data <= next_rx_shift;
					rx_byte_o.err  <= rx_err_seen | (rx_err_i & !rx_mode_serial);
					rx_byte_o.last <= 1'b0;
					rx_toggle      <= ~rx_toggle;
					if (rx_da_count != 4'(`MPS_DA_BYTES))
						rx_da_count <= rx_da_count + 4'd1;
					if (rx_da_count == 4'(`MPS_DA_BYTES - 1))
						rx_da_o <= {next_rx_shift, rx_da_o[47:8]};
					else if (rx_da_count < 4'(`MPS_DA_BYTES))
						rx_da_o <= {next_rx_shift, rx_da_o[47:8]};
				end
			end
			// asserted once the destination address is in
			if (rx_mode_serial && rx_da_count == 4'(`MPS_DA_BYTES))
				packet_compress_output_o <= compress_hit ~^
				                            compress_cfg_i.polarity_high; // RQ5
			else
				packet_compress_output_o <= ~compress_cfg_i.polarity_high;
		end
	end

	// ----------------------------------------------------------------
	// system domain: byte strobe crossing and carrier sense
	// ----------------------------------------------------------------
	logic rx_toggle_sync;
	logic rx_toggle_seen;
	logic carrier_sync;

	mps_sync #(.WIDTH(2)) u_sys_sync
	(
		.clk_i   (sys_clk_i),
		.reset_i (reset_i),
		.async_i ({rx_toggle, carrier_sense_i}), // RQ16
		.sync_o  ({rx_toggle_sync, carrier_sync})
	);

	always_ff @(posedge sys_clk_i)
	begin
		if (reset_i)
		begin
			rx_toggle_seen  <= 1'b0;
			rx_byte_valid_o <= 1'b0;
			carrier_o       <= 1'b0;
		end
		else
		begin
			rx_toggle_seen  <= rx_toggle_sync;
			rx_byte_valid_o <= rx_toggle_sync ^ rx_toggle_seen;
			carrier_o       <= carrier_sync; // RQ16
		end
	end
endmodule : mps_pin_logic
`default_nettype wire

// file: core/mps_consts.svh
// constants for the nibble / seven-wire pin logic
`ifndef MPS_CONSTS_SVH
`define MPS_CONSTS_SVH
`define MPS_NIBBLE_W 4
`define MPS_BYTE_W 8
`define MPS_DA_BYTES 6
`define MPS_DA_BITS 48
`define MPS_SYNC_STAGES 2
`define MPS_SFD_BYTE 8'hD5
`define MPS_PRE_NIBBLE 4'h5
`endif

// file: core/mps_pkg.sv
// types for the nibble / seven-wire pin logic
package mps_pkg;
	typedef enum logic {MPS_MODE_NIBBLE, MPS_MODE_SERIAL} mps_mode_type;
	typedef struct packed
	{
		logic [7:0] data;
		logic       last;
		logic       err;
	} mps_byte_type;
	typedef struct packed
	{
		logic       polarity_high;
		logic       on_mismatch;
	} mps_compress_cfg_type;
endpackage : mps_pkg

// file: core/mps_sync.sv
// two-flip-flop level synchroniser, parameterised width
`timescale 1ns/1ps
`default_nettype none
module mps_sync
#(
	parameter int WIDTH = 1
)
(
	input  wire logic             clk_i,
	input  wire logic             reset_i,
	input  wire logic [WIDTH-1:0] async_i,
	output logic      [WIDTH-1:0] sync_o
);
	logic [WIDTH-1:0] stage1;

	initial
	begin
		if (WIDTH < 1)
			$error("mps_sync: width must be at least one");
	end

	always_ff @(posedge clk_i)
	begin
		if (reset_i)
		begin
			stage1 <= '0;
			sync_o <= '0;
		end
		else
		begin
			stage1 <= async_i;
			sync_o <= stage1;
		end
	end
endmodule : mps_sync
`default_nettype wire

// file: tb/mps_pin_logic_checker.sv
// port assertions for the nibble / seven-wire pin logic
`timescale 1ns/1ps
`default_nettype none
module mps_pin_logic_checker
	import mps_pkg::*;
(
	input wire logic                 sys_clk_i,
	input wire logic                 reset_i,
	input wire logic                 tx_clk_i,
	input wire logic                 rx_clk_i,
	input wire mps_mode_type         mode_i,
	input wire mps_compress_cfg_type compress_cfg_i,
	input wire logic                 tx_start_i,
	input wire logic [7:0]           tx_byte_i,
	input wire logic                 carrier_sense_i,
	input wire logic                 tx_take_o,
	input wire logic [3:0]           txd_o,
	input wire logic                 tx_en_o,
	input wire logic                 tx_err_o,
	input wire logic                 serial_transmit_enable_o,
	input wire logic                 packet_compress_output_o,
	input wire logic                 carrier_o
);
	// ----
	// transmit
	// ----
	a_start_taken: assert property (@(posedge tx_clk_i) disable iff (reset_i)
		mode_i == MPS_MODE_NIBBLE && !tx_en_o && tx_start_i |=> tx_en_o &&
		tx_take_o && {4'h0, txd_o} == ($past(tx_byte_i) & 8'h0F))
		else $error("first nibble not launched after start");
	a_take_spacing: assert property (@(posedge tx_clk_i) disable iff (reset_i)
		mode_i == MPS_MODE_NIBBLE && tx_take_o |=> !tx_take_o && tx_en_o)
		else $error("byte not held for two nibbles");
	a_enable_cause: assert property (@(posedge tx_clk_i) disable iff (reset_i)
		$rose(tx_en_o) |-> $past(tx_start_i))
		else $error("transmit enable rose without start");
	a_err_framed: assert property (@(posedge tx_clk_i) disable iff (reset_i)
		tx_err_o |-> tx_en_o || serial_transmit_enable_o || $past(tx_en_o) ||
		$past(serial_transmit_enable_o))
		else $error("transmit error outside a frame");
	a_mode_select: assert property (@(posedge tx_clk_i) disable iff (reset_i)
		mode_i == MPS_MODE_NIBBLE ? !serial_transmit_enable_o : !tx_en_o)
		else $error("wrong framing output for mode");
	// ----
	// receive and carrier
	// ----
	a_carrier_sync: assert property (@(posedge sys_clk_i) disable iff (reset_i)
		$rose(carrier_o) |-> $past(carrier_sense_i, 2))
		else $error("carrier passed too few stages");
	a_compress_nibble: assert property (@(posedge rx_clk_i) disable iff (reset_i)
		mode_i == MPS_MODE_NIBBLE |->
		packet_compress_output_o == !compress_cfg_i.polarity_high)
		else $error("compress active in nibble mode");
	a_compress_early: assert property (@(posedge rx_clk_i) disable iff (reset_i)
		$rose(carrier_sense_i) |->
		packet_compress_output_o == !compress_cfg_i.polarity_high)
		else $error("compress active before address");
endmodule : mps_pin_logic_checker
bind mps_pin_logic mps_pin_logic_checker i_mps_pin_logic_checker (.sys_clk_i,
	.reset_i, .tx_clk_i, .rx_clk_i, .mode_i, .compress_cfg_i, .tx_start_i,
	.tx_byte_i, .carrier_sense_i, .tx_take_o, .txd_o, .tx_en_o, .tx_err_o,
	.serial_transmit_enable_o, .packet_compress_output_o, .carrier_o);
`default_nettype wire

// file: tb/mps_phy_model.sv
// behavioural PHY / serial endec facing the pin logic
`timescale 1ns/1ps
`default_nettype none
module mps_phy_model
(
	input  wire logic       serial_tx_en_i,
	output logic            tx_clk_o,
	output logic            rx_clk_o,
	output logic [3:0]      rxd_o,
	output logic            rx_dv_o,
	output logic            rx_err_o,
	output wire logic       carrier_sense_o
);
	logic rx_car;
	// ----
	// clocks and lines
	// ----
	initial
	begin
		tx_clk_o = 1'h0;
		#3;
		forever #7.5 tx_clk_o = ~tx_clk_o;
	end
	initial
	begin
		rx_clk_o = 1'h0;
		#7;
		forever #7.5 rx_clk_o = ~rx_clk_o;
	end
	initial
	begin
		rxd_o = 4'h0;
		rx_dv_o = 1'h0;
		rx_err_o = 1'h0;
		rx_car = 1'h0;
	end
	assign carrier_sense_o = rx_car | serial_tx_en_i;
	task put(input logic [3:0] n, input logic v);
		@(negedge rx_clk_o);
		rxd_o = n;
		rx_dv_o = v;
	endtask : put
	// preamble, delimiter, then the six address bytes, low byte first
	task rx_frame(input logic ser, input logic [47:0] da);
		logic [71:0] f;
		int i, k;
		f = {da, 8'hD5, 8'h55, 8'h55};
		rx_car = 1'h1;
		for (i = 0; i < 9; i++)
		begin
			if (ser)
				for (k = 0; k < 8; k++)
					put({~rxd_o[3:1], f[8 * i + k]}, 1'h0);
			else
			begin
				put(f[8 * i +: 4], 1'h1);
				put(f[8 * i + 4 +: 4], 1'h1);
			end
		end
	endtask : rx_frame
	// released lines show the inverse so a stale value never passes
	task rx_stop;
		put(~rxd_o, 1'h0);
		rx_car = 1'h0;
	endtask : rx_stop
endmodule : mps_phy_model
`default_nettype wire

// file: tb/test_mps_pin_logic.sv
// self-checking bench for the nibble / seven-wire pin logic
`timescale 1ns/1ps
`default_nettype none
module test_mps_pin_logic;
	import mps_pkg::*;
	logic clk, rst, start, last, err_req, match, err_seen;
	logic [7:0] tx_byte;
	mps_mode_type mode;
	mps_compress_cfg_type cfg;
	wire logic tx_clk, rx_clk, dv, rerr, crs, take, tx_en, tx_err, ser_en;
	wire logic packet_compress_signal, rx_valid, carrier;
	wire logic [3:0] rxd, txd;
	wire logic [47:0] rx_da;
	mps_byte_type rx_byte;
	wire logic ser = (mode == MPS_MODE_SERIAL);
	int fail_count = 0;
	int checks = 0;
	int rx_count = 0;
	logic [7:0] bytes [8] = '{8'h55, 8'h55, 8'hD5, 8'hA3, 8'h0F, 8'hF0,
		8'h96, 8'h00};
	mps_pin_logic i_mps_pin_logic (.sys_clk_i(clk), .reset_i(rst),
		.tx_clk_i(tx_clk), .rx_clk_i(rx_clk), .mode_i(mode),
		.compress_cfg_i(cfg), .tx_start_i(start), .tx_byte_i(tx_byte),
		.tx_last_i(last), .tx_error_req_i(err_req), .da_match_i(match),
		.rxd_i(rxd), .rx_dv_i(dv), .rx_err_i(rerr), .carrier_sense_i(crs),
		.tx_take_o(take), .txd_o(txd), .tx_en_o(tx_en), .tx_err_o(tx_err),
		.serial_transmit_enable_o(ser_en), .packet_compress_output_o(packet_compress_signal),
		.rx_byte_o(rx_byte), .rx_byte_valid_o(rx_valid), .rx_da_o(rx_da),
		.carrier_o(carrier));
	mps_phy_model i_mps_phy_model (.serial_tx_en_i(ser_en),
		.tx_clk_o(tx_clk), .rx_clk_o(rx_clk), .rxd_o(rxd), .rx_dv_o(dv),
		.rx_err_o(rerr), .carrier_sense_o(crs));
	// ----
	// helpers
	// ----
	initial
	begin
		clk = 1'h0;
		forever #25 clk = ~clk;
	end
	always @(posedge tx_clk)
		if (tx_err === 1'h1)
			err_seen = 1'h1;
	// byte strobes seen on the system side
	always @(posedge clk)
		if (rx_valid === 1'h1)
			rx_count++;
	task chk(input logic ok);
		checks++;
		if (ok !== 1'h1)
		begin
			$display("ERROR %0t mismatch", $time);
			fail_count++;
		end
	endtask : chk
	task test_done;
		$display("checks %0d fail_count %0d", checks, fail_count);
		if (fail_count == 0 && checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : test_done
	// one loop walks the byte rows; nibbles or bits follow from the mode
	task tx_frame(input int n);
		int i, k, w;
		@(posedge tx_clk);
		#1;
		start = 1'h1;
		tx_byte = bytes[0];
		last = (n == 1);
		for (i = 0; i < n; i++)
		begin
			w = 0;
			do
			begin
				@(posedge tx_clk);
				#1;
				w++;
			end
			while (take !== 1'h1 && w < 20);
			start = 1'h0;
			chk(ser ? ser_en === 1'h1 && txd[0] === bytes[i][0] :
				tx_en === 1'h1 && txd === bytes[i][3:0]);
			tx_byte = bytes[i + 1];
			last = (i + 2 == n);
			for (k = 1; k < (ser ? 8 : 2); k++)
			begin
				@(posedge tx_clk);
				#1;
				chk(ser ? txd[0] === bytes[i][k] :
					txd === bytes[i][7:4] && tx_en === 1'h1);
			end
		end
		@(posedge tx_clk);
		#1;
		chk(tx_en === 1'h0 && ser_en === 1'h0);
	endtask : tx_frame
	// ----
	// sequence
	// ----
	initial
	begin
		#100us;
		fail_count++;
		test_done;
	end
	initial
	begin
		rst = 1'h1;
		mode = MPS_MODE_NIBBLE;
		cfg = '{1'h1, 1'h1};
		{start, last, err_req, match, err_seen} = 5'h00;
		tx_byte = 8'h00;
		repeat (10) @(posedge clk);
		chk({tx_en, take, ser_en, packet_compress_signal, carrier, rx_valid, tx_err, txd,
			rx_da} === 59'h0);
		#1 rst = 1'h0;
		repeat (8) @(posedge tx_clk);
		#1;
		err_req = 1'h1;
		tx_frame(7);
		err_req = 1'h0;
		chk(err_seen === 1'h1);
		repeat (2) @(posedge tx_clk);
		#1;
		err_seen = 1'h0;
		tx_frame(1);
		chk(err_seen === 1'h0);
		match = 1'h1;
		i_mps_phy_model.rx_frame(1'h0, 48'hC3B2_A190_7F01);
		repeat (4) @(posedge clk);
		chk(carrier === 1'h1);
		i_mps_phy_model.rx_stop;
		repeat (10) @(posedge clk);
		chk(rx_da === 48'hC3B2_A190_7F01 && carrier === 1'h0);
		#1;
		mode = MPS_MODE_SERIAL;
		match = 1'h0;
		// mode crosses into the transmit domain through two flops
		repeat (4) @(posedge tx_clk);
		tx_frame(2);
		rx_count = 0;
		i_mps_phy_model.rx_frame(1'h1, 48'h0E1D_2C3B_4A59);
		repeat (4) @(posedge rx_clk);
		#1;
		chk(packet_compress_signal === 1'h1);
		i_mps_phy_model.rx_stop;
		repeat (10) @(posedge clk);
		chk(packet_compress_signal === 1'h0 && rx_da === 48'h0E1D_2C3B_4A59);
		chk(rx_count == 6 && rx_byte.data === 8'h0E);
		chk(rx_byte.err === 1'h0 && rx_byte.last === 1'h0);
		// low polarity, assert on a match
		#1;
		cfg = '{1'h0, 1'h0};
		match = 1'h1;
		repeat (4) @(posedge rx_clk);
		#1;
		chk(packet_compress_signal === 1'h1);
		i_mps_phy_model.rx_frame(1'h1, 48'h6B7A_8998_A7B6);
		repeat (4) @(posedge rx_clk);
		#1;
		chk(packet_compress_signal === 1'h0);
		i_mps_phy_model.rx_stop;
		repeat (10) @(posedge clk);
		chk(packet_compress_signal === 1'h1 && rx_da === 48'h6B7A_8998_A7B6);
		test_done;
	end
endmodule : test_mps_pin_logic
`default_nettype wire
